// file: hdl/dbgtp_defines.svh
// Timing, reset and exception constants for the debug and test pin logic.
// Assumes inclusion by bare name from the design file.
`ifndef DBGTP_DEFINES_SVH
`define DBGTP_DEFINES_SVH

// Reset assertion synchroniser depth in input clocks
`define DBGTP_RST_SYNC_STAGES 2
// Reset values
`define DBGTP_BREF_CLK_RST 1'h1
`define DBGTP_FLOAT_LATCH_RST 1'h0
// Exception code for the breakpoint trap
`define DBGTP_EXC_BREAK 5'h09

`endif

// file: hdl/dbgtp_pkg.sv
// Types for the debug and test pin logic.
// Assumes nothing beyond the defines header.
package dbgtp_pkg;
	typedef enum logic [1:0] {
		DBGTP_IDLE,
		DBGTP_RD_ADDR,
		DBGTP_RD_DATA,
		DBGTP_WRITE
	} dbgtp_phase_e;
endpackage : dbgtp_pkg

// file: hdl/dbgtp_pins.sv
// Debug and test pin logic: output float, bus clock phase set, access kind pin, break trap.
// Assumes core transaction strobes on core_clk; float request and reset pin are asynchronous.
`timescale 1ns/1ps
`include "dbgtp_defines.svh"
`default_nettype none

// Overview of operation
// - Active-low float request releases every output pin of the device.
// - Float also releases bus reference clock, timer terminal count and bus grant.
// - Once floated, outputs stay released until a reset has been applied.
// - Reset pin falling edge is synchronised to the input clock within two clocks.
// - Synchronised reset assertion drives bus reference clock high in the next phase.
// - Bus reference clock keeps toggling through reset after that forced-high phase while the input clock runs.
// - In read address phase access kind is high for cache miss, low uncacheable.
// - After the address phase access kind is high for instruction, low for data.
// - Executing the breakpoint instruction raises an exception.
module dbgtp_pins (
	// Clock and pin-level reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Tester float request
	input wire logic output_float_request_n,
	// Core bus activity
	input wire logic rd_start,
	input wire logic rd_cache_miss,
	input wire logic rd_instr,
	input wire logic wr_start,
	input wire logic xfer_done,
	input wire logic dma_hold,
	// Core timer, grant and instruction decode
	input wire logic timer_count_hit,
	input wire logic bus_grant,
	input wire logic break_exec,
	// Pin outputs with enables, enable low while driving
	output logic bus_reference_clock_out,
	output logic bus_reference_clock_oe_n,
	output logic timer_terminal_count_out,
	output logic timer_terminal_count_oe_n,
	output logic bus_grant_out,
	output logic bus_grant_oe_n,
	output logic access_kind_out,
	output logic access_kind_oe_n,
	output logic bus_pins_oe_n,
	// Core side
	output logic core_reset_n,
	output logic break_exception,
	output logic [4:0] exception_code
);
	logic [`DBGTP_RST_SYNC_STAGES-1:0] rst_sync_reg;
	logic [1:0] float_sync_reg;
	logic float_latch_reg;
	logic bref_clk_reg;
	logic tc_reg;
	logic grant_reg;
	logic kind_reg;
	logic core_rst_n_reg;
	logic brk_reg;
	logic [4:0] exc_reg;
	logic floated_reg;
	logic dma_float_reg;
	dbgtp_pkg::dbgtp_phase_e phase_reg;
	dbgtp_pkg::dbgtp_phase_e phase_next;

	// Reset seen internally; the pin itself only feeds the synchroniser
	wire int_rst = ~rst_sync_reg[`DBGTP_RST_SYNC_STAGES-1];
	wire float_req = ~float_sync_reg[1];
	wire floated_next = float_latch_reg | float_req;
	wire kind_next = (phase_next == dbgtp_pkg::DBGTP_RD_ADDR) ? rd_cache_miss :
		(phase_next == dbgtp_pkg::DBGTP_RD_DATA) ? rd_instr : kind_reg;

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			dbgtp_pkg::DBGTP_IDLE: begin
				if (rd_start)
					phase_next = dbgtp_pkg::DBGTP_RD_ADDR;
				else if (wr_start)
					phase_next = dbgtp_pkg::DBGTP_WRITE;
			end
			dbgtp_pkg::DBGTP_RD_ADDR: begin
				phase_next = xfer_done ? dbgtp_pkg::DBGTP_IDLE : dbgtp_pkg::DBGTP_RD_DATA;
			end
			dbgtp_pkg::DBGTP_RD_DATA, dbgtp_pkg::DBGTP_WRITE: begin
				if (xfer_done)
					phase_next = dbgtp_pkg::DBGTP_IDLE;
			end
			default: begin
				phase_next = dbgtp_pkg::DBGTP_IDLE;
			end
		endcase
	end

	// Two-stage synchronisers; the pin reset does not gate these flops
	always_ff @(posedge core_clk) begin
		rst_sync_reg <= {rst_sync_reg[`DBGTP_RST_SYNC_STAGES-2:0], rst_b};
		float_sync_reg <= {float_sync_reg[0], output_float_request_n};
	end

	// Bus reference clock: forced high on reset take-over, free running otherwise
	// An unknown reset history falls to the set branch, so the phase is known after power-up
	always_ff @(posedge core_clk) begin
		if (!int_rst || !core_rst_n_reg)
			bref_clk_reg <= ~bref_clk_reg;
		else
			bref_clk_reg <= `DBGTP_BREF_CLK_RST;
		core_rst_n_reg <= ~int_rst;
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			float_latch_reg <= `DBGTP_FLOAT_LATCH_RST;
			floated_reg <= 1'b0;
			dma_float_reg <= 1'b0;
			phase_reg <= dbgtp_pkg::DBGTP_IDLE;
			kind_reg <= 1'b0;
			tc_reg <= 1'b0;
			grant_reg <= 1'b0;
			brk_reg <= 1'b0;
			exc_reg <= 5'h00;
		end else begin
			float_latch_reg <= floated_next;
			floated_reg <= floated_next;
			dma_float_reg <= floated_next | dma_hold;
			phase_reg <= phase_next;
			kind_reg <= kind_next;
			tc_reg <= timer_count_hit;
			grant_reg <= bus_grant;
			brk_reg <= break_exec;
			exc_reg <= break_exec ? `DBGTP_EXC_BREAK : exc_reg;
		end
	end

	assign bus_reference_clock_out = bref_clk_reg;
	assign bus_reference_clock_oe_n = floated_reg;
	assign timer_terminal_count_out = tc_reg;
	assign timer_terminal_count_oe_n = floated_reg;
	assign bus_grant_out = grant_reg;
	assign bus_grant_oe_n = floated_reg;
	assign access_kind_out = kind_reg;
	assign access_kind_oe_n = dma_float_reg;
	assign bus_pins_oe_n = dma_float_reg;
	assign core_reset_n = core_rst_n_reg;
	assign break_exception = brk_reg;
	assign exception_code = exc_reg;

	property p_float_holds;
		@(posedge core_clk) disable iff (int_rst)
		floated_reg |=> floated_reg;
	endproperty
	a_float_holds: assert property (p_float_holds) else $error("float released without reset");

	property p_float_all;
		@(posedge core_clk) disable iff (int_rst)
		floated_reg |-> (bus_reference_clock_oe_n && timer_terminal_count_oe_n && bus_grant_oe_n &&
			bus_pins_oe_n && access_kind_oe_n);
	endproperty
	a_float_all: assert property (p_float_all) else $error("output still driven under float");

	property p_float_enter;
		@(posedge core_clk) disable iff (int_rst)
		float_req |=> floated_reg;
	endproperty
	a_float_enter: assert property (p_float_enter) else $error("float request not honoured");

	property p_rst_sync;
		@(posedge core_clk)
		$fell(rst_b) |-> ##[1:2] int_rst;
	endproperty
	a_rst_sync: assert property (p_rst_sync) else $error("reset not synchronised in two clocks");

	property p_clk_high;
		@(posedge core_clk)
		$rose(int_rst) |=> bref_clk_reg;
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("bus clock not high after reset");

	property p_clk_runs;
		@(posedge core_clk)
		(int_rst && $past(int_rst) && !core_rst_n_reg) |=> (bref_clk_reg != $past(bref_clk_reg));
	endproperty
	a_clk_runs: assert property (p_clk_runs) else $error("bus clock stopped in reset");

	property p_kind_addr;
		@(posedge core_clk) disable iff (int_rst)
		(phase_reg == dbgtp_pkg::DBGTP_IDLE && rd_start) |=> (access_kind_out == $past(rd_cache_miss));
	endproperty
	a_kind_addr: assert property (p_kind_addr) else $error("address phase kind wrong");

	property p_kind_data;
		@(posedge core_clk) disable iff (int_rst)
		(phase_reg == dbgtp_pkg::DBGTP_RD_ADDR && !xfer_done) |=> (access_kind_out == $past(rd_instr));
	endproperty
	a_kind_data: assert property (p_kind_data) else $error("data phase kind wrong");

	property p_break;
		@(posedge core_clk) disable iff (int_rst)
		break_exec |=> (break_exception && exception_code == `DBGTP_EXC_BREAK);
	endproperty
	a_break: assert property (p_break) else $error("break did not trap");

	property p_break_clears;
		@(posedge core_clk) disable iff (int_rst)
		!break_exec |=> !break_exception;
	endproperty
	a_break_clears: assert property (p_break_clears) else $error("break trap without break");

	property p_dma_float;
		@(posedge core_clk) disable iff (int_rst)
		dma_hold |=> (bus_pins_oe_n && access_kind_oe_n);
	endproperty
	a_dma_float: assert property (p_dma_float) else $error("bus pins driven during dma");

	property p_dma_drives_rest;
		@(posedge core_clk) disable iff (int_rst)
		(dma_hold && !floated_reg && !float_req) |=> !(bus_reference_clock_oe_n || timer_terminal_count_oe_n || bus_grant_oe_n);
	endproperty
	a_dma_drives_rest: assert property (p_dma_drives_rest) else $error("clock, count or grant released by dma");

	property p_reset_drives;
		@(posedge core_clk)
		int_rst |=> !(bus_pins_oe_n || access_kind_oe_n || bus_reference_clock_oe_n);
	endproperty
	a_reset_drives: assert property (p_reset_drives) else $error("float not cleared by reset");

	property p_core_rst;
		@(posedge core_clk)
		int_rst |=> !core_reset_n;
	endproperty
	a_core_rst: assert property (p_core_rst) else $error("core reset not asserted");

	property p_kind_write;
		@(posedge core_clk) disable iff (int_rst)
		(phase_reg == dbgtp_pkg::DBGTP_WRITE) |=> $stable(access_kind_out);
	endproperty
	a_kind_write: assert property (p_kind_write) else $error("kind pin moved during write");
endmodule : dbgtp_pins

`default_nettype wire

// file: bench/dbgtp_tester.sv
// Board tester model that drives the active-low float request.
// Assumes the bench commands it and resets the block after use.
`timescale 1ns/1ps
`default_nettype none
module dbgtp_tester (
	// Bench command and pin
	input wire logic float_cmd,
	output logic output_float_request_n
);
	assign output_float_request_n = ~float_cmd;
endmodule : dbgtp_tester
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the debug and test pin logic.
// Assumes dbgtp_pins and dbgtp_tester are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, rst_b = 0, rd_start = 0, rd_cache_miss = 0, rd_instr = 0, wr_start = 0;
	logic xfer_done = 0, dma_hold = 0, timer_count_hit = 0, bus_grant = 0, break_exec = 0, float_cmd = 0;
	logic output_float_request_n, bus_reference_clock_out, bus_reference_clock_oe_n, timer_terminal_count_out;
	logic timer_terminal_count_oe_n, bus_grant_out, bus_grant_oe_n, access_kind_out, access_kind_oe_n;
	logic bus_pins_oe_n, core_reset_n, break_exception, ph0, ph1;
	logic [4:0] exception_code;
	int bad_count = 0, check_count = 0, cyc = 0;
	always #2.5 core_clk = ~core_clk;
	dbgtp_tester tester (.float_cmd, .output_float_request_n);
	dbgtp_pins uut (.core_clk, .rst_b, .output_float_request_n, .rd_start, .rd_cache_miss, .rd_instr,
		.wr_start, .xfer_done, .dma_hold, .timer_count_hit, .bus_grant, .break_exec,
		.bus_reference_clock_out, .bus_reference_clock_oe_n, .timer_terminal_count_out,
		.timer_terminal_count_oe_n, .bus_grant_out, .bus_grant_oe_n, .access_kind_out,
		.access_kind_oe_n, .bus_pins_oe_n, .core_reset_n, .break_exception, .exception_code);
	task conclude;
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 500) begin
			bad_count++;
			conclude();
		end
	end
	task chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %b exp %b", $time, got, exp);
		end
	endtask : chk
	task cyc_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc_n
	// Phase seen four cycles into reset must not depend on prior phase
	task do_reset(output logic ph);
		rst_b = 0;
		cyc_n(4);
		ph = bus_reference_clock_out;
		cyc_n(1);
		chk(bus_reference_clock_out, ~ph);
		chk(core_reset_n, 1'b0);
		rst_b = 1;
		cyc_n(4);
		chk(core_reset_n, 1'b1);
	endtask : do_reset
	task t_read(input logic miss, input logic ins);
		rd_start = 1;
		rd_cache_miss = miss;
		rd_instr = ins;
		cyc_n(1);
		rd_start = 0;
		chk(access_kind_out, miss);
		cyc_n(1);
		chk(access_kind_out, ins);
		xfer_done = 1;
		cyc_n(1);
		xfer_done = 0;
	endtask : t_read
	// Write leaves the kind pin alone; it must still show the 1 left by the last read
	task t_write;
		wr_start = 1;
		rd_cache_miss = 1'b0;
		rd_instr = 1'b0;
		cyc_n(1);
		wr_start = 0;
		chk(access_kind_out, 1'b1);
		xfer_done = 1;
		cyc_n(1);
		xfer_done = 0;
		chk(access_kind_out, 1'b1);
	endtask : t_write
	task t_break;
		break_exec = 1;
		cyc_n(1);
		break_exec = 0;
		chk(break_exception, 1'b1);
		chk(exception_code === 5'h09, 1'b1);
		cyc_n(1);
		chk(break_exception, 1'b0);
	endtask : t_break
	// DMA floats bus pins and the access kind pin only; clock, count and grant stay driven
	task t_dma;
		dma_hold = 1;
		timer_count_hit = 1;
		bus_grant = 1;
		cyc_n(2);
		chk(bus_pins_oe_n & access_kind_oe_n, 1'b1);
		chk(bus_reference_clock_oe_n | bus_grant_oe_n | timer_terminal_count_oe_n, 1'b0);
		chk(timer_terminal_count_out & bus_grant_out, 1'b1);
		dma_hold = 0;
		cyc_n(2);
		chk(access_kind_oe_n, 1'b0);
	endtask : t_dma
	task t_float;
		float_cmd = 1;
		cyc_n(4);
		chk(&{bus_reference_clock_oe_n, timer_terminal_count_oe_n, bus_grant_oe_n}, 1'b1);
		chk(access_kind_oe_n & bus_pins_oe_n, 1'b1);
		float_cmd = 0;
		cyc_n(4);
		chk(bus_reference_clock_oe_n & bus_pins_oe_n, 1'b1);
		if (cyc % 2 == 0)
			cyc_n(1);
		do_reset(ph1);
		chk(bus_pins_oe_n | bus_reference_clock_oe_n, 1'b0);
		chk(ph1, ph0);
	endtask : t_float
	initial begin
		do_reset(ph0);
		t_read(1'b1, 1'b0);
		t_read(1'b0, 1'b1);
		t_write();
		t_break();
		t_dma();
		t_float();
		conclude();
	end
endmodule : tb
`default_nettype wire
